// ---- rso_core.sv ----
// Top of the datapath: Wishbone register slave, four-phase sequencer,
// bank addressing, watchdog and sleep control.
// Assumes a Wishbone classic master on the one clock.
`default_nettype none

module rso_core import rso_pkg::*; #(
  parameter int TICK_CYCLES = WDT_TICK_CYC,
  parameter int POST_DIV = WDT_POST_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic asleep_o
);

  if (TICK_CYCLES < 2 || POST_DIV < 2) begin : g_bad_wdt
    $error("rso_core: watchdog divider counts must be at least 2");
  end

  localparam int PW = $clog2(TICK_CYCLES);
  localparam int QW = $clog2(POST_DIV);

  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} rso_phase_type;

  function automatic logic [7:0] wbyte(input logic [7:0] old, input logic [7:0] nw,
                                       input logic en);
    return en ? nw : old;
  endfunction

  rso_phase_type phase;
  logic [15:0] instr;
  logic [7:0] acc;
  rso_flags_type flags;
  logic [3:0] bank_select_reg;
  logic [11:0] idx_base;
  logic [11:0] mem_addr;
  logic ext_en;
  logic asleep;
  logic to_bit;
  logic pd_bit;
  logic illegal;
  logic busy_q;
  logic pend;
  rso_alu_out_type alu_q;
  rso_alu_out_type alu_out;
  logic [7:0] mem_rdata;
  logic [PW-1:0] wdt_pre;
  logic [QW-1:0] wdt_post;

  // Decode
  wire rso_op_type op = rso_decode(instr);
  wire d_bit = instr[9];
  wire a_bit = instr[8];
  wire [7:0] f = instr[7:0];
  wire busy = (phase != PH_IDLE);
  wire q4 = (phase == PH_Q4);
  wire has_dest = op inside {OP_RRNC, OP_SUB_FILE_FROM_ACC_BORROW_OP, OP_SUB_ACC_FROM_FILE_OP, OP_SUB_ACC_FROM_FILE_BORROW_OP};
  wire to_file = (op == OP_SET_ALL_ONES_OP) || (has_dest && d_bit);
  wire to_acc = (op == OP_SUB_ACC_FROM_LITERAL_OP) || (has_dest && !d_bit);

  wire indexed = ext_en && !a_bit && (f <= ACCESS_LIMIT);
  wire [11:0] idx_addr = idx_base + {4'h0, f};
  wire [11:0] acc_bank_addr = (f <= ACCESS_LIMIT) ? {ACCESS_LOW_BANK, f} : {ACCESS_HI_BANK, f};
  wire [11:0] file_addr = indexed ? idx_addr : a_bit ? {bank_select_reg, f} : acc_bank_addr;

  // Bus decode
  wire req = cyc_i && stb_i;
  wire go = req && pend && !ack_o && !busy && !busy_q;
  wire wr = go && we_i;
  wire hit_ctrl = (adr_i == REG_CTRL);
  wire hit_instr = (adr_i == REG_INSTR);
  wire hit_acc = (adr_i == REG_ACC);
  wire hit_status = (adr_i == REG_STATUS);
  wire hit_bank = (adr_i == REG_BANK);
  wire hit_index = (adr_i == REG_INDEX);
  wire hit_power = (adr_i == REG_POWER);
  wire hit_wdt = (adr_i == REG_WDT);
  wire hit_maddr = (adr_i == REG_MADDR);
  wire hit_mdata = (adr_i == REG_MDATA);
  wire start = wr && hit_instr && !asleep;
  wire wake_req = wr && hit_ctrl && sel_i[0] && dat_i[CTRL_WAKE_BIT];
  wire wr_mdata = wr && hit_mdata && sel_i[0];
  wire [7:0] idx_hi = wbyte({4'h0, idx_base[11:8]}, dat_i[15:8], sel_i[1]);
  wire [7:0] maddr_hi = wbyte({4'h0, mem_addr[11:8]}, dat_i[15:8], sel_i[1]);

  wire [31:0] pwr_word = 32'({illegal, pd_bit, to_bit, asleep, busy});
  wire [31:0] rd_word =
    hit_ctrl ? 32'(ext_en) :
    hit_instr ? 32'(instr) :
    hit_acc ? 32'(acc) :
    hit_status ? 32'(flags) :
    hit_bank ? 32'(bank_select_reg) :
    hit_index ? 32'(idx_base) :
    hit_power ? pwr_word :
    hit_wdt ? 32'({wdt_post, wdt_pre}) :
    hit_maddr ? 32'(mem_addr) :
    hit_mdata ? 32'(mem_rdata) : 32'h00000000;

  // Memory port
  wire [11:0] mem_a = busy ? file_addr : mem_addr;
  wire mem_we = (q4 && to_file) || wr_mdata;
  wire [7:0] mem_wd = busy ? alu_q.res : dat_i[7:0];

  rso_mem #(
    .DEPTH(FILE_DEPTH),
    .AW(FILE_AW)
  ) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .addr_i(mem_a),
    .wdata_i(mem_wd),
    .rdata_o(mem_rdata)
  );

  rso_alu u_alu (
    .op_i(op),
    .acc_i(acc),
    .file_i(mem_rdata),
    .lit_i(f),
    .flags_i(flags),
    .out_o(alu_out)
  );

  // Watchdog prescaler and postscaler
  wire tick = (wdt_pre == PW'(TICK_CYCLES - 1));
  wire wdt_timeout = tick && (wdt_post == QW'(POST_DIV - 1));
  wire sleep_now = q4 && (op == OP_SLEEP);

  always_ff @(posedge clk_i) begin
    if (rst_i || sleep_now) begin
      wdt_pre <= '0;
      wdt_post <= '0;
    end else begin
      wdt_pre <= tick ? '0 : wdt_pre + 1'b1;
      if (tick) begin
        wdt_post <= wdt_timeout ? '0 : wdt_post + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= PH_IDLE;
    end else begin
      unique case (phase)
        PH_IDLE: if (start) phase <= PH_Q1;
        PH_Q1: phase <= PH_Q2;
        PH_Q2: phase <= PH_Q3;
        PH_Q3: phase <= PH_Q4;
        PH_Q4: phase <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alu_q <= '0;
    end else if (phase == PH_Q3) begin
      alu_q <= alu_out;
    end
  end

  // Accumulator and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= ACC_RST;
      flags <= '0;
    end else begin
      if (q4 && to_acc) acc <= alu_q.res;
      else if (wr && hit_acc) acc <= wbyte(acc, dat_i[7:0], sel_i[0]);
      if (q4) flags <= alu_q.flags;
      else if (wr && hit_status && sel_i[0]) flags <= dat_i[4:0];
    end
  end

  // Software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr <= 16'h0000;
      bank_select_reg <= 4'h0;
      idx_base <= 12'h000;
      mem_addr <= 12'h000;
      ext_en <= 1'b0;
    end else if (wr) begin
      if (start) instr <= {wbyte(instr[15:8], dat_i[15:8], sel_i[1]),
                           wbyte(instr[7:0], dat_i[7:0], sel_i[0])};
      if (hit_bank && sel_i[0]) bank_select_reg <= dat_i[3:0];
      if (hit_index) idx_base <= {idx_hi[3:0], wbyte(idx_base[7:0], dat_i[7:0], sel_i[0])};
      if (hit_maddr) mem_addr <= {maddr_hi[3:0], wbyte(mem_addr[7:0], dat_i[7:0], sel_i[0])};
      if (hit_ctrl && sel_i[0]) ext_en <= dat_i[CTRL_EXT_BIT];
    end
  end

  // Sleep and power status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      asleep <= 1'b0;
      to_bit <= TO_RST;
      pd_bit <= PD_RST;
      illegal <= 1'b0;
    end else begin
      if (start) illegal <= 1'b0;
      else if (phase == PH_Q1 && op == OP_NONE) illegal <= 1'b1;
      if (sleep_now) begin
        asleep <= 1'b1;
        to_bit <= 1'b1;
        pd_bit <= 1'b0;
      end else if (asleep && wdt_timeout) begin
        asleep <= 1'b0;
        to_bit <= 1'b0;
      end else if (asleep && wake_req) begin
        asleep <= 1'b0;
      end
    end
  end

  // Wishbone classic slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
      pend <= req && !ack_o && !go;
      ack_o <= go;
      if (go) dat_o <= rd_word;
    end
  end

  assign asleep_o = asleep;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rotate;
    (phase == PH_Q3 && op == OP_RRNC) |=>
      alu_q.res == {$past(mem_rdata[0]), $past(mem_rdata[7:1])};
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate result wrong");

  property p_dest_acc;
    (q4 && has_dest && !d_bit) |=> acc == $past(alu_q.res);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator not written");

  property p_bank;
    (phase == PH_Q2 && a_bit) |-> mem_a == {bank_select_reg, f};
  endproperty
  a_bank: assert property (p_bank) else $error("bank select address wrong");

  property p_indexed;
    (phase == PH_Q2 && ext_en && !a_bit && f <= ACCESS_LIMIT) |-> mem_a == idx_base + {4'h0, f};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_sleep;
    sleep_now |=> asleep && to_bit && !pd_bit && wdt_pre == '0 && wdt_post == '0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

  property p_wdt_wake;
    (asleep && wdt_timeout) |=> !asleep && !to_bit;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_sub_file_from_acc_borrow_op;
    (phase == PH_Q3 && op == OP_SUB_FILE_FROM_ACC_BORROW_OP) |=>
      alu_q.res == $past(acc - mem_rdata - {7'h00, ~flags.c});
  endproperty
  a_sub_file_from_acc_borrow_op: assert property (p_sub_file_from_acc_borrow_op) else $error("borrow subtract wrong");

  property p_sub_acc_from_literal_op;
    (q4 && op == OP_SUB_ACC_FROM_LITERAL_OP) |=> acc == $past(f - acc);
  endproperty
  a_sub_acc_from_literal_op: assert property (p_sub_acc_from_literal_op) else $error("literal subtract wrong");

  property p_sub_acc_from_file_op;
    (phase == PH_Q3 && op == OP_SUB_ACC_FROM_FILE_OP) |=> alu_q.res == $past(mem_rdata - acc);
  endproperty
  a_sub_acc_from_file_op: assert property (p_sub_acc_from_file_op) else $error("file subtract wrong");

  property p_sub_acc_from_file_borrow_op;
    (phase == PH_Q3 && op == OP_SUB_ACC_FROM_FILE_BORROW_OP) |=>
      alu_q.res == $past(mem_rdata - acc - {7'h00, ~flags.c});
  endproperty
  a_sub_acc_from_file_borrow_op: assert property (p_sub_acc_from_file_borrow_op) else $error("file borrow subtract wrong");

  property p_set_all_ones_op_flags;
    (q4 && op == OP_SET_ALL_ONES_OP) |=> $stable(flags);
  endproperty
  a_set_all_ones_op_flags: assert property (p_set_all_ones_op_flags) else $error("flags changed");

  property p_four_phase;
    (phase == PH_Q1) |=> phase == PH_Q2 ##1 phase == PH_Q3 ##1 phase == PH_Q4 ##1 !busy;
  endproperty
  a_four_phase: assert property (p_four_phase) else $error("phase order wrong");

  property p_carry;
    (phase == PH_Q3 && op == OP_SUB_ACC_FROM_FILE_OP) |=> alu_q.flags.c == ($past(mem_rdata) >= $past(acc))
      && alu_q.flags.z == (alu_q.res == 8'h00) && alu_q.flags.n == alu_q.res[7];
  endproperty
  a_carry: assert property (p_carry) else $error("subtract flags wrong");

  property p_set_all_ones_op;
    (q4 && op == OP_SET_ALL_ONES_OP) |-> mem_we && mem_wd == ALL_ONES && mem_a == file_addr;
  endproperty
  a_set_all_ones_op: assert property (p_set_all_ones_op) else $error("set all ones not written");

  c_sleep: cover property (sleep_now);
  c_wdt_wake: cover property (asleep && wdt_timeout);
  c_borrow: cover property (q4 && op == OP_SUB_ACC_FROM_FILE_BORROW_OP && !alu_q.flags.c);
  c_set_all_ones_op: cover property (q4 && op == OP_SET_ALL_ONES_OP);

endmodule // rso_core

`default_nettype wire

// ---- rso_pkg.sv ----
// Shared constants, types and decoding for the rotate/subtract/sleep datapath.
// Assumes a single 10 MHz clock and a Wishbone classic register bus.
// Functional notes
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Access bit 0 uses the access bank; 1 uses bank select register.
// - Access bit 0, extension on, address up to 95: indexed literal offset mode.
// - Sleep clears watchdog and postscaler, sets time-out, clears power-down, then sleeps.
// - A watchdog wake-up clears the time-out status bit.
// - Subtract file from accumulator with borrow: acc minus file minus inverted carry.
// - Subtract from literal: literal minus accumulator into accumulator.
// - Subtract accumulator from file: file minus accumulator to the destination.
// - Subtract accumulator from file with borrow: file minus acc minus inverted carry.
// - Subtracts update N, OV, C, DC, Z; set-all-ones leaves flags alone.
// - Each instruction takes one cycle of four phases: decode, read, process, write.
`default_nettype none

package rso_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WDT_TICK_NS = 1000000;
  localparam int WDT_TICK_CYC = WDT_TICK_NS / CLK_PERIOD_NS;
  localparam int WDT_POST_DIV = 16;

  // File memory
  localparam int FILE_DEPTH = 4096;
  localparam int FILE_AW = 12;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_BANK = 8'h10;
  localparam logic [7:0] REG_INDEX = 8'h14;
  localparam logic [7:0] REG_POWER = 8'h18;
  localparam logic [7:0] REG_WDT = 8'h1C;
  localparam logic [7:0] REG_MADDR = 8'h20;
  localparam logic [7:0] REG_MDATA = 8'h24;

  // Field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int PWR_BUSY_BIT = 0;
  localparam int PWR_SLEEP_BIT = 1;
  localparam int PWR_TO_BIT = 2;
  localparam int PWR_PD_BIT = 3;
  localparam int PWR_ILL_BIT = 4;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;

  // Opcode patterns
  localparam logic [5:0] OPC_RRNC = 6'h10;
  localparam logic [5:0] OPC_SUB_FILE_FROM_ACC_BORROW_OP = 6'h15;
  localparam logic [5:0] OPC_SUB_ACC_FROM_FILE_BORROW_OP = 6'h16;
  localparam logic [5:0] OPC_SUB_ACC_FROM_FILE_OP = 6'h17;
  localparam logic [6:0] OPC_SET_ALL_ONES_OP = 7'h34;
  localparam logic [7:0] OPC_SUB_ACC_FROM_LITERAL_OP = 8'h08;
  localparam logic [15:0] OPC_SLEEP = 16'h0003;

  typedef enum logic [2:0] {
    OP_NONE, OP_RRNC, OP_SET_ALL_ONES_OP, OP_SUB_FILE_FROM_ACC_BORROW_OP, OP_SUB_ACC_FROM_LITERAL_OP, OP_SUB_ACC_FROM_FILE_OP, OP_SUB_ACC_FROM_FILE_BORROW_OP, OP_SLEEP
  } rso_op_type;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } rso_flags_type;

  typedef struct packed {
    logic [7:0] res;
    rso_flags_type flags;
  } rso_alu_out_type;

  function automatic rso_op_type rso_decode(input logic [15:0] ins);
    rso_op_type op;
    op = OP_NONE;
    if (ins == OPC_SLEEP) op = OP_SLEEP;
    else if (ins[15:8] == OPC_SUB_ACC_FROM_LITERAL_OP) op = OP_SUB_ACC_FROM_LITERAL_OP;
    else if (ins[15:9] == OPC_SET_ALL_ONES_OP) op = OP_SET_ALL_ONES_OP;
    else if (ins[15:10] == OPC_RRNC) op = OP_RRNC;
    else if (ins[15:10] == OPC_SUB_FILE_FROM_ACC_BORROW_OP) op = OP_SUB_FILE_FROM_ACC_BORROW_OP;
    else if (ins[15:10] == OPC_SUB_ACC_FROM_FILE_BORROW_OP) op = OP_SUB_ACC_FROM_FILE_BORROW_OP;
    else if (ins[15:10] == OPC_SUB_ACC_FROM_FILE_OP) op = OP_SUB_ACC_FROM_FILE_OP;
    return op;
  endfunction

endpackage

`default_nettype wire

// ---- rso_mem.sv ----
// File register memory with registered read data.
// Assumes one port; write and read share the address.
`default_nettype none

module rso_mem import rso_pkg::*; #(
  parameter int DEPTH = FILE_DEPTH,
  parameter int AW = FILE_AW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_bad_depth
    $error("rso_mem: depth does not fit the address width");
  end

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule // rso_mem

`default_nettype wire

// ---- rso_alu.sv ----
// Result and flag computation for rotate, set-all-ones and subtract forms.
// Assumes operands are stable for the process phase.
`default_nettype none

module rso_alu import rso_pkg::*; (
  input wire rso_op_type op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] file_i,
  input wire logic [7:0] lit_i,
  input wire rso_flags_type flags_i,
  output rso_alu_out_type out_o
);

  wire is_sub = op_i inside {OP_SUB_FILE_FROM_ACC_BORROW_OP, OP_SUB_ACC_FROM_LITERAL_OP, OP_SUB_ACC_FROM_FILE_OP, OP_SUB_ACC_FROM_FILE_BORROW_OP};
  wire use_borrow = op_i inside {OP_SUB_FILE_FROM_ACC_BORROW_OP, OP_SUB_ACC_FROM_FILE_BORROW_OP};
  wire [7:0] sub_x = (op_i == OP_SUB_FILE_FROM_ACC_BORROW_OP) ? acc_i : (op_i == OP_SUB_ACC_FROM_LITERAL_OP) ? lit_i : file_i;
  wire [7:0] sub_y = (op_i == OP_SUB_FILE_FROM_ACC_BORROW_OP) ? file_i : acc_i;
  wire carry_in = use_borrow ? flags_i.c : 1'b1;
  wire [8:0] sum9 = {1'b0, sub_x} + {1'b0, ~sub_y} + {8'h00, carry_in};
  wire [4:0] nib5 = {1'b0, sub_x[3:0]} + {1'b0, ~sub_y[3:0]} + {4'h0, carry_in};
  wire [7:0] rot = {file_i[0], file_i[7:1]};

  always_comb begin
    out_o.flags = flags_i;
    out_o.res = file_i;
    if (is_sub) begin
      out_o.res = sum9[7:0];
      out_o.flags.n = sum9[7];
      out_o.flags.ov = (sub_x[7] != sub_y[7]) && (sum9[7] != sub_x[7]);
      out_o.flags.z = (sum9[7:0] == 8'h00);
      out_o.flags.dc = nib5[4];
      out_o.flags.c = sum9[8];
    end else if (op_i == OP_RRNC) begin
      out_o.res = rot;
      out_o.flags.n = rot[7];
      out_o.flags.z = (rot == 8'h00);
    end else if (op_i == OP_SET_ALL_ONES_OP) begin
      out_o.res = ALL_ONES;
    end
  end

endmodule // rso_alu

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the rotate, subtract and sleep datapath.
// Assumes the core's Wishbone classic slave and shortened watchdog counts.
`default_nettype none

module tb_top import rso_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_i;
  logic [7:0] adr_i;
  logic [31:0] dat_i;
  logic [3:0] sel_i;
  logic we_i;
  logic cyc_i;
  logic stb_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic asleep_o;
  logic [31:0] q;
  logic [12:0] e13;
  int err_total = 0;
  int n_checks = 0;
  int n;

  always #50 clk_i = ~clk_i;

  rso_core #(.TICK_CYCLES(40), .POST_DIV(2)) i_rso_core (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .asleep_o(asleep_o)
  );

  task automatic finish_test;
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 100);
    if (k >= 100) begin
      err_total++;
      $display("CHECK FAILED t=%0t no ack", $time);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0);
    chk(q, e, s);
  endtask

  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    wr(REG_MADDR, {20'h0, a});
    wr(REG_MDATA, {24'h0, d});
  endtask

  task automatic peek(input logic [11:0] a, input logic [7:0] e);
    wr(REG_MADDR, {20'h0, a});
    rc(REG_MDATA, {24'h0, e}, "file");
  endtask

  task automatic ex(input logic [15:0] i);
    wr(REG_INSTR, {16'h0, i});
  endtask

  // Result and {N,OV,Z,DC,C} of x + ~y + ci
  function automatic logic [12:0] subm(input logic [7:0] x, input logic [7:0] y,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, x} + {1'b0, ~y} + {8'h0, ci};
    h = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, ci};
    return {s[7:0], s[7], (x[7] != y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  task automatic tsub(input logic [5:0] op, input logic d, input logic [7:0] fv,
                      input logic [7:0] acc, input logic ci);
    logic [12:0] e;
    if (op == OPC_SUB_FILE_FROM_ACC_BORROW_OP) e = subm(acc, fv, ci);
    else e = subm(fv, acc, (op == OPC_SUB_ACC_FROM_FILE_OP) ? 1'b1 : ci);
    poke(12'h045, fv);
    wr(REG_ACC, {24'h0, acc});
    wr(REG_STATUS, {31'h0, ci});
    ex({op, d, 1'b0, 8'h45});
    rc(REG_STATUS, {27'h0, e[4:0]}, "flags");
    rc(REG_ACC, {24'h0, d ? acc : e[12:5]}, "acc");
    peek(12'h045, d ? e[12:5] : fv);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    finish_test;
  end

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rc(REG_POWER, 32'h0000000C, "power reset");
    rc(REG_ACC, 32'h0, "acc reset");
    wr(8'h30, 32'hFFFFFFFF);
    rc(8'h30, 32'h0, "unmapped");
    tsub(OPC_SUB_FILE_FROM_ACC_BORROW_OP, 1'b1, 8'h03, 8'h02, 1'b1);
    tsub(OPC_SUB_FILE_FROM_ACC_BORROW_OP, 1'b1, 8'h02, 8'h05, 1'b1);
    tsub(OPC_SUB_FILE_FROM_ACC_BORROW_OP, 1'b0, 8'h01, 8'h02, 1'b0);
    tsub(OPC_SUB_ACC_FROM_FILE_OP, 1'b1, 8'h03, 8'h02, 1'b0);
    tsub(OPC_SUB_ACC_FROM_FILE_OP, 1'b0, 8'h02, 8'h02, 1'b0);
    tsub(OPC_SUB_ACC_FROM_FILE_OP, 1'b1, 8'h80, 8'h01, 1'b1);
    tsub(OPC_SUB_ACC_FROM_FILE_BORROW_OP, 1'b1, 8'h19, 8'h0D, 1'b1);
    tsub(OPC_SUB_ACC_FROM_FILE_BORROW_OP, 1'b0, 8'h1B, 8'h1A, 1'b0);
    tsub(OPC_SUB_ACC_FROM_FILE_BORROW_OP, 1'b1, 8'h03, 8'h0E, 1'b1);
    for (int i = 1; i < 4; i++) begin
      e13 = subm(8'h02, i[7:0], 1'b1);
      wr(REG_ACC, {24'h0, i[7:0]});
      ex({OPC_SUB_ACC_FROM_LITERAL_OP, 8'h02});
      rc(REG_ACC, {24'h0, e13[12:5]}, "literal acc");
      rc(REG_STATUS, {27'h0, e13[4:0]}, "literal flags");
    end
    wr(REG_STATUS, 32'h0F);
    poke(12'h045, 8'hD7);
    ex({OPC_RRNC, 1'b1, 1'b0, 8'h45});
    peek(12'h045, 8'hEB);
    rc(REG_STATUS, 32'h1B, "rotate flags");
    poke(12'h045, 8'h01);
    ex({OPC_RRNC, 1'b0, 1'b0, 8'h45});
    rc(REG_ACC, 32'h80, "rotate acc");
    peek(12'h045, 8'h01);
    wr(REG_STATUS, 32'h15);
    wr(REG_BANK, 32'h3);
    ex({OPC_SET_ALL_ONES_OP, 1'b1, 8'h45});
    peek(12'h345, 8'hFF);
    peek(12'h045, 8'h01);
    ex({OPC_SET_ALL_ONES_OP, 1'b0, 8'hA0});
    peek(12'hFA0, 8'hFF);
    rc(REG_STATUS, 32'h15, "set flags");
    wr(REG_INDEX, 32'h123);
    wr(REG_CTRL, 32'h1);
    poke(12'h133, 8'h00);
    poke(12'hF60, 8'h00);
    ex({OPC_SET_ALL_ONES_OP, 1'b0, 8'h10});
    peek(12'h133, 8'hFF);
    ex({OPC_SET_ALL_ONES_OP, 1'b0, 8'h60});
    peek(12'hF60, 8'hFF);
    wr(REG_CTRL, 32'h0);
    ex(16'hFFFF);
    rc(REG_POWER, 32'h1C, "illegal");
    ex({OPC_SUB_ACC_FROM_LITERAL_OP, 8'h00});
    rc(REG_POWER, 32'h0C, "illegal clear");
    ex(OPC_SLEEP);
    rc(REG_POWER, 32'h06, "sleep status");
    chk({31'h0, asleep_o}, 32'h1, "asleep");
    wr(REG_ACC, 32'h55);
    ex({OPC_SUB_ACC_FROM_LITERAL_OP, 8'h00});
    rc(REG_ACC, 32'h55, "refused in sleep");
    n = 0;
    while (asleep_o !== 1'b0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, asleep_o}, 32'h0, "watchdog wake");
    rc(REG_POWER, 32'h00, "wake status");
    ex(OPC_SLEEP);
    wr(REG_CTRL, 32'h2);
    rc(REG_POWER, 32'h04, "soft wake status");
    chk({31'h0, asleep_o}, 32'h0, "soft wake");
    finish_test;
  end
endmodule // tb_top

`default_nettype wire
